// ==== hw/tsb_batch_scan.sv ====
// Contract
// - a 16-bit config word holds the test mode in bits 11:8 and batch delay in bits 2:0, the rest reserved.
// - test-mode codes 0 to 11 each pick one ascending panel resistance range from 0.17 up to 32.6 kilohm.
// - test-mode codes 12 to 14 are reserved and unused, and code 15 is only for the short-circuit panel test.
// - batch delay codes 0 to 7 pick 0, 1, 2, 4, 10, 20, 40 or 100 ms between sample sets.
// - batch delay code 0 applies no pacing, so sets follow one another as fast as the converter runs.
// - pacing applies to both device-initiated and host-initiated XYZ or XY scans.
// - a device-initiated scan starts on pen touch, and the delay timer starts with that first set.
// - a set that ends before the delay expires leaves the scan waiting until the timer ends.
// - at timer expiry with the pen still down the next set runs and the timer restarts at full value.
// - when one set takes longer than the delay, the set time governs the repeat interval.
// - an engaged host-initiated scan is paced by the delay timer while the original touch lasts.
// - batch scanning ends when the pen lifts, when the stop bit is written, or on any reset.
// - writing one to the stop bit aborts the running function at once, even with pen down, and powers down.
module tsb_batch_scan
    import tsb_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = TSB_CYC_PER_MS
)
(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        pen_detect_in,
    input  wire logic        set_done_in,
    output logic             set_start_out,
    output logic             converter_abort_out,
    output logic             converter_busy_out,
    output logic      [3:0]  connection_test_mode_out,
    output logic             short_test_out
);

    // reset release
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_b;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_b = rst_sync_reg;

    // pen pin synchroniser
    logic pen_meta_reg;
    logic pen_sync_reg;

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            pen_meta_reg <= 1'b0;
            pen_sync_reg <= 1'b0;
        end else begin
            pen_meta_reg <= pen_detect_in;
            pen_sync_reg <= pen_meta_reg;
        end
    end

    // bus address phase capture
    logic       addr_ok;
    logic       wr_pend_reg;
    logic       wr_pend_next;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_addr_next;

    assign addr_ok = hsel_in && htrans_in[1] && hready_in && (hsize_in == 3'h2);

    always_comb begin
        wr_pend_next = addr_ok && hwrite_in;
        wr_addr_next = addr_ok ? haddr_in[7:0] : wr_addr_reg;
    end

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
        end
    end

    logic cfg_wr;
    logic ctl_wr;
    logic stop_req;
    logic func_wr;

    assign cfg_wr   = wr_pend_reg && (wr_addr_reg == TSB_OFS_CONFIG);
    assign ctl_wr   = wr_pend_reg && (wr_addr_reg == TSB_OFS_CONTROL);
    // stop is self-clearing: it exists only as this write strobe
    assign stop_req = ctl_wr && hwdata_in[TSB_CTL_STOP_BIT];
    assign func_wr  = ctl_wr && !hwdata_in[TSB_CTL_STOP_BIT];

    // configuration word
    logic [TSB_TMODE_W-1:0] tmode_reg;
    logic [TSB_TMODE_W-1:0] tmode_next;
    logic [TSB_BATCH_W-1:0] batch_sel_reg;
    logic [TSB_BATCH_W-1:0] batch_sel_next;
    logic [TSB_TMODE_W-1:0] tmode_wdata;
    logic [15:0]            cfg_word;

    assign tmode_wdata = hwdata_in[TSB_TMODE_LSB +: TSB_TMODE_W];

    always_comb begin
        tmode_next     = tmode_reg;
        batch_sel_next = batch_sel_reg;
        if (cfg_wr) begin
            // reserved test codes are refused; the old mode stays
            if (tmode_wdata < TSB_TMODE_RSV_LO || tmode_wdata > TSB_TMODE_RSV_HI) begin
                tmode_next = tmode_wdata;
            end
            batch_sel_next = hwdata_in[TSB_BATCH_LSB +: TSB_BATCH_W];
        end
    end

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            tmode_reg     <= TSB_CFG_RESET[TSB_TMODE_LSB +: TSB_TMODE_W];
            batch_sel_reg <= TSB_CFG_RESET[TSB_BATCH_LSB +: TSB_BATCH_W];
        end else begin
            tmode_reg     <= tmode_next;
            batch_sel_reg <= batch_sel_next;
        end
    end

    always_comb begin
        cfg_word                                  = 16'h0000;
        cfg_word[TSB_TMODE_LSB +: TSB_TMODE_W]    = tmode_reg;
        cfg_word[TSB_BATCH_LSB +: TSB_BATCH_W]    = batch_sel_reg;
    end

    // the analog range selector decodes codes 0..11 as ascending ranges
    assign connection_test_mode_out = tmode_reg;
    assign short_test_out           = (tmode_reg == TSB_TMODE_SHORT);

    // delay length in clock cycles
    logic [TSB_CNT_W-1:0] delay_cycles;
    logic                 tmr_load;
    logic                 tmr_expired;

    always_comb begin
        delay_cycles = TSB_CNT_W'(TSB_BATCH_MS[batch_sel_reg] * CYCLES_PER_MS);
    end

    // code 0 loads zero, so the timer is already expired when the set ends
    tsb_delay_timer u_timer (
        .clock_in      (clock_in),
        .rst_b_in      (rst_b),
        .load_in       (tmr_load),
        .load_value_in (delay_cycles),
        .expired_out   (tmr_expired)
    );

    // scan control
    tsb_state_t             state_reg;
    tsb_state_t             state_next;
    logic                   init_sel_reg;
    logic                   init_sel_next;
    logic [TSB_FUNC_W-1:0]  func_reg;
    logic [TSB_FUNC_W-1:0]  func_next;
    logic                   func_act_reg;
    logic                   func_act_next;
    logic                   start_reg;
    logic                   start_next;
    logic                   abort_reg;
    logic                   abort_next;
    logic [TSB_SETCNT_W-1:0] set_cnt_reg;
    logic [TSB_SETCNT_W-1:0] set_cnt_next;
    logic [TSB_FUNC_W-1:0]  func_wdata;
    logic                   batch_wfunc;
    logic                   batch_func;
    logic                   launch;
    logic                   finish;

    assign func_wdata  = hwdata_in[TSB_CTL_FUNC_LSB +: TSB_FUNC_W];
    assign batch_wfunc = (func_wdata == TSB_FUNC_XYZ) || (func_wdata == TSB_FUNC_XY);
    assign batch_func  = func_act_reg && ((func_reg == TSB_FUNC_XYZ) || (func_reg == TSB_FUNC_XY));

    always_comb begin
        state_next    = state_reg;
        init_sel_next = init_sel_reg;
        func_next     = func_reg;
        func_act_next = func_act_reg;
        abort_next    = 1'b0;
        launch        = 1'b0;
        finish        = 1'b0;
        if (func_wr) begin
            init_sel_next = hwdata_in[TSB_CTL_INIT_BIT];
            func_next     = func_wdata;
        end
        if (stop_req) begin
            // abort even with the pen down
            state_next    = TSB_IDLE;
            func_act_next = 1'b0;
            abort_next    = 1'b1;
        end else begin
            case (state_reg)
                TSB_IDLE: begin
                    if (func_wr && batch_wfunc) begin
                        if (hwdata_in[TSB_CTL_INIT_BIT]) begin
                            func_act_next = 1'b1;
                            state_next    = TSB_ARMED;
                        end else if (pen_sync_reg) begin
                            // host engages only after a touch is seen
                            func_act_next = 1'b1;
                            launch        = 1'b1;
                        end
                    end
                end
                TSB_ARMED: begin
                    if (!init_sel_reg || !batch_func) begin
                        state_next    = TSB_IDLE;
                        func_act_next = 1'b0;
                    end else if (pen_sync_reg) begin
                        launch = 1'b1;
                    end
                end
                TSB_SAMPLE: begin
                    if (set_done_in) begin
                        if (!pen_sync_reg) begin
                            finish = 1'b1;
                        end else if (tmr_expired) begin
                            // set took longer than the delay
                            launch = 1'b1;
                        end else begin
                            state_next = TSB_WAIT;
                        end
                    end
                end
                TSB_WAIT: begin
                    if (!pen_sync_reg) begin
                        finish = 1'b1;
                    end else if (tmr_expired) begin
                        launch = 1'b1;
                    end
                end
                default: begin
                    state_next = TSB_IDLE;
                end
            endcase
            if (launch) begin
                state_next = TSB_SAMPLE;
            end
            // device mode keeps its function armed for the next touch
            if (finish) begin
                if (init_sel_reg) begin
                    state_next = TSB_ARMED;
                end else begin
                    state_next    = TSB_IDLE;
                    func_act_next = 1'b0;
                end
            end
        end
        start_next = launch;
        if (launch) begin
            set_cnt_next = set_cnt_reg + 1'b1;
        end else begin
            set_cnt_next = set_cnt_reg;
        end
    end

    // timer restarts with every set launch
    assign tmr_load = launch;

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= TSB_IDLE;
            init_sel_reg <= TSB_INIT_RESET;
            func_reg     <= TSB_FUNC_RESET;
            func_act_reg <= 1'b0;
            start_reg    <= 1'b0;
            abort_reg    <= 1'b0;
            set_cnt_reg  <= '0;
        end else begin
            state_reg    <= state_next;
            init_sel_reg <= init_sel_next;
            func_reg     <= func_next;
            func_act_reg <= func_act_next;
            start_reg    <= start_next;
            abort_reg    <= abort_next;
            set_cnt_reg  <= set_cnt_next;
        end
    end

    assign set_start_out       = start_reg;
    assign converter_abort_out = abort_reg;

    logic busy;

    assign busy               = (state_reg == TSB_SAMPLE) || (state_reg == TSB_WAIT);
    assign converter_busy_out = busy;

    // read data is latched in the address phase, so no wait states
    logic [31:0] status_word;
    logic [31:0] ctl_word;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;

    always_comb begin
        status_word                                = 32'h0000_0000;
        status_word[TSB_STS_PEN_BIT]               = pen_sync_reg;
        status_word[TSB_STS_IDLE_BIT]              = !busy;
        status_word[TSB_STS_WAIT_BIT]              = (state_reg == TSB_WAIT);
        status_word[TSB_STS_ACT_BIT]               = func_act_reg;
        status_word[TSB_STS_ST_LSB +: 2]           = state_reg;
        ctl_word                                   = 32'h0000_0000;
        ctl_word[TSB_CTL_INIT_BIT]                 = init_sel_reg;
        ctl_word[TSB_CTL_FUNC_LSB +: TSB_FUNC_W]   = func_reg;
    end

    always_comb begin
        hrdata_next = hrdata_reg;
        if (addr_ok && !hwrite_in) begin
            case (haddr_in[7:0])
                TSB_OFS_CONFIG:   hrdata_next = {16'h0000, cfg_word};
                TSB_OFS_CONTROL:  hrdata_next = ctl_word;
                TSB_OFS_STATUS:   hrdata_next = status_word;
                TSB_OFS_SETCOUNT: hrdata_next = {16'h0000, set_cnt_reg};
                default:          hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            hrdata_reg <= 32'h0000_0000;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    assign hrdata_out    = hrdata_reg;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

endmodule

// ==== include/tsb_pkg.sv ====
package tsb_pkg;

    // clock and time base
    localparam int unsigned TSB_CLK_HZ       = 100_000_000;
    localparam int unsigned TSB_MS_PER_S     = 1000;
    localparam int unsigned TSB_CYC_PER_MS   = TSB_CLK_HZ / TSB_MS_PER_S;
    localparam int unsigned TSB_CNT_W        = 24;

    // batch delay per code, in milliseconds
    localparam int unsigned TSB_BATCH_MS [8] = '{0, 1, 2, 4, 10, 20, 40, 100};

    // register byte offsets
    localparam logic [7:0]  TSB_OFS_CONFIG   = 8'h00;
    localparam logic [7:0]  TSB_OFS_CONTROL  = 8'h04;
    localparam logic [7:0]  TSB_OFS_STATUS   = 8'h08;
    localparam logic [7:0]  TSB_OFS_SETCOUNT = 8'h0C;

    // configuration word layout
    localparam int unsigned TSB_CFG_W        = 16;
    localparam int unsigned TSB_TMODE_LSB    = 8;
    localparam int unsigned TSB_TMODE_W      = 4;
    localparam int unsigned TSB_BATCH_LSB    = 0;
    localparam int unsigned TSB_BATCH_W      = 3;
    localparam logic [15:0] TSB_CFG_RESET    = 16'h0000;

    // test-mode codes
    localparam logic [3:0]  TSB_TMODE_RSV_LO = 4'hC;
    localparam logic [3:0]  TSB_TMODE_RSV_HI = 4'hE;
    localparam logic [3:0]  TSB_TMODE_SHORT  = 4'hF;

    // control word layout
    localparam int unsigned TSB_CTL_INIT_BIT = 0;
    localparam int unsigned TSB_CTL_FUNC_LSB = 4;
    localparam int unsigned TSB_FUNC_W       = 4;
    localparam int unsigned TSB_CTL_STOP_BIT = 8;
    localparam logic        TSB_INIT_RESET   = 1'b0;
    localparam logic [3:0]  TSB_FUNC_RESET   = 4'h0;
    localparam logic [3:0]  TSB_FUNC_XYZ     = 4'h0;
    localparam logic [3:0]  TSB_FUNC_XY      = 4'h1;

    // status word layout
    localparam int unsigned TSB_STS_PEN_BIT  = 0;
    localparam int unsigned TSB_STS_IDLE_BIT = 1;
    localparam int unsigned TSB_STS_WAIT_BIT = 2;
    localparam int unsigned TSB_STS_ACT_BIT  = 3;
    localparam int unsigned TSB_STS_ST_LSB   = 4;

    localparam int unsigned TSB_SETCNT_W     = 16;

    typedef enum logic [1:0] {
        TSB_IDLE   = 2'b00,
        TSB_ARMED  = 2'b01,
        TSB_SAMPLE = 2'b10,
        TSB_WAIT   = 2'b11
    } tsb_state_t;

endpackage

// ==== hw/tsb_delay_timer.sv ====
module tsb_delay_timer
    import tsb_pkg::*;
(
    input  wire logic                 clock_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 load_in,
    input  wire logic [TSB_CNT_W-1:0] load_value_in,
    output logic                      expired_out
);

    logic [TSB_CNT_W-1:0] count_reg;
    logic [TSB_CNT_W-1:0] count_next;

    // one count per clock; a load restarts from the full value
    always_comb begin
        if (load_in) begin
            count_next = load_value_in;
        end else if (count_reg != '0) begin
            count_next = count_reg - 1'b1;
        end else begin
            count_next = count_reg;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // must not look at load_in: the launch that loads the timer is itself decided from this flag
    assign expired_out = (count_reg == '0);

endmodule

// ==== testbench/tsb_batch_scan_asserts.sv ====
module tsb_batch_scan_asserts
    import tsb_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = TSB_CYC_PER_MS
)
(
    input wire logic        clock_in,
    input wire logic        rst_b_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [2:0]  hsize_in,
    input wire logic        hready_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        pen_detect_in,
    input wire logic        set_start_out,
    input wire logic        converter_abort_out,
    input wire logic        converter_busy_out,
    input wire logic [3:0]  connection_test_mode_out,
    input wire logic        short_test_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    logic       take_reg;
    logic [7:0] ofs_reg;
    logic [2:0] code_reg;
    logic       paced_reg;
    int         gap_reg;
    wire        cfg_wr = take_reg && ofs_reg == TSB_OFS_CONFIG;
    // delay code shadowed from bus writes; assumes no config change mid-scan
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            take_reg  <= 1'b0;
            ofs_reg   <= 8'h00;
            code_reg  <= 3'h0;
            paced_reg <= 1'b0;
            gap_reg   <= 0;
        end else begin
            take_reg  <= hsel_in && htrans_in[1] && hready_in && hwrite_in && hsize_in == 3'h2;
            ofs_reg   <= haddr_in[7:0];
            code_reg  <= cfg_wr ? hwdata_in[2:0] : code_reg;
            paced_reg <= set_start_out || (paced_reg && converter_busy_out);
            gap_reg   <= set_start_out ? 1 : gap_reg + 1;
        end
    end
    sequence s_stop_wr;
        take_reg && ofs_reg == TSB_OFS_CONTROL && hwdata_in[TSB_CTL_STOP_BIT] && converter_busy_out;
    endsequence
    // sync latency plus one launch register
    sequence s_pen_gone;
        !pen_detect_in [*6];
    endsequence
    property p_start; set_start_out |-> converter_busy_out ##1 !set_start_out; endproperty
    a_start: assert property (p_start) else $error("start pulse malformed");
    property p_abort; converter_abort_out |-> !converter_busy_out ##1 !converter_abort_out; endproperty
    a_abort: assert property (p_abort) else $error("abort pulse malformed");
    property p_short; short_test_out == (connection_test_mode_out == TSB_TMODE_SHORT); endproperty
    a_short: assert property (p_short) else $error("short test decode wrong");
    property p_no_rsv; !(connection_test_mode_out inside {[TSB_TMODE_RSV_LO:TSB_TMODE_RSV_HI]}); endproperty
    a_no_rsv: assert property (p_no_rsv) else $error("reserved test mode held");
    property p_mode_hold; !cfg_wr |=> $stable(connection_test_mode_out); endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("test mode changed unwritten");
    property p_mode_wr; cfg_wr && hwdata_in[11:8] < TSB_TMODE_RSV_LO |=> connection_test_mode_out == $past(hwdata_in[11:8]); endproperty
    a_mode_wr: assert property (p_mode_wr) else $error("test mode not written");
    property p_pace; set_start_out && paced_reg |-> gap_reg + 1 >= TSB_BATCH_MS[code_reg] * CYCLES_PER_MS; endproperty
    a_pace: assert property (p_pace) else $error("set started before delay end");
    property p_stop; s_stop_wr |-> ##[1:2] (converter_abort_out && !converter_busy_out); endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");
    property p_pen; s_pen_gone |-> !set_start_out; endproperty
    a_pen: assert property (p_pen) else $error("set started without pen");
endmodule

bind tsb_batch_scan tsb_batch_scan_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS)) tsb_batch_scan_asserts_i (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hready_in(hready_in), .hwdata_in(hwdata_in),
    .pen_detect_in(pen_detect_in), .set_start_out(set_start_out), .converter_abort_out(converter_abort_out),
    .converter_busy_out(converter_busy_out), .connection_test_mode_out(connection_test_mode_out),
    .short_test_out(short_test_out));

// ==== testbench/tsb_panel_model.sv ====
module tsb_panel_model (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic       set_start_in,
    input  wire logic       abort_in,
    input  wire logic [7:0] set_cycles_in,
    output logic            set_done_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int left;
    // set length is the bench's choice so it can outrun the batch delay
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in || abort_in) begin
            left <= 0;
            set_done_out <= 1'b0;
        end else begin
            set_done_out <= left == 1;
            if (set_start_in) begin
                left <= set_cycles_in;
            end else if (left > 0) begin
                left <= left - 1;
            end
        end
    end
endmodule

// ==== testbench/touch_scan_batch_delay_tb_top.sv ====
module touch_scan_batch_delay_tb_top;
    import tsb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CPM = 10;
    logic        clock_in, rst_b_in, hsel, hwrite, hready, hresp, pen, done, start, abort, busy, short_t;
    logic [31:0] haddr, hwdata, hrdata, rv, wd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  tmode, m_tmode;
    logic [7:0]  set_cyc;
    int          failures = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          n_abort = 0;
    int          seed, n0, n1, code;
    int          starts[$];

    tsb_batch_scan #(.CYCLES_PER_MS(CPM)) tsb_batch_scan_i (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .pen_detect_in(pen), .set_done_in(done),
        .set_start_out(start), .converter_abort_out(abort), .converter_busy_out(busy),
        .connection_test_mode_out(tmode), .short_test_out(short_t));
    tsb_panel_model tsb_panel_model_i (.clock_in(clock_in), .rst_b_in(rst_b_in), .set_start_in(start),
        .abort_in(abort), .set_cycles_in(set_cyc), .set_done_out(done));

    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    // sampled mid-cycle so the main sequence never races the log
    always @(negedge clock_in) begin
        cyc <= cyc + 1;
        if (start === 1'b1) starts.push_back(cyc);
        if (abort === 1'b1) n_abort <= n_abort + 1;
    end

    task automatic tally_and_finish();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_rdy();
        @(posedge clock_in);
        for (int i = 0; hready !== 1'b1; i++) begin
            if (i > 50) begin
                failures++;
                $display("FAIL hready expected 1 seen %b", hready);
                tally_and_finish();
            end
            @(posedge clock_in);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask
    // n above zero waits until the launch log holds n launches in total, zero waits for the scan to end
    task automatic wait_for(input int n);
        for (int i = 0; n > 0 ? starts.size() < n : busy !== 1'b0; i++) begin
            if (i > 3000) begin
                failures++;
                $display("FAIL wait expected event %0d seen timeout", n);
                tally_and_finish();
            end
            @(posedge clock_in);
        end
    endtask
    // one cycle of slack: set end to restart goes through a register
    task automatic chk_gaps(input int ix, input int c);
        int dly;
        int s;
        int g;
        dly = TSB_BATCH_MS[c] * CPM;
        s = set_cyc;
        for (int j = ix + 1; j < ix + 3; j++) begin
            g = starts[j] - starts[j - 1];
            n_compared++;
            if (g < (dly > s + 2 ? dly - 1 : s + 1) || g > (dly > s + 3 ? dly + 1 : s + 4)) begin
                failures++;
                $display("FAIL interval expected %0d ms seen %0d cycles", TSB_BATCH_MS[c], g);
            end
        end
    endtask

    initial begin
        seed = 51;
        {rst_b_in, hsel, hwrite, pen, htrans, haddr, hwdata, m_tmode} = '0;
        hsize = 3'b010;
        set_cyc = 8'h03;
        repeat (8) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        bus(1'b0, TSB_OFS_CONFIG, 32'h0, rv);
        chk("config reset", 32'h0, rv);
        bus(1'b0, TSB_OFS_STATUS, 32'h0, rv);
        chk("status reset", 32'h2, rv);
        bus(1'b0, 8'h10, 32'h0, rv);
        chk("unmapped", 32'h0, rv);
        for (int i = 0; i < 16; i++) begin
            wd = $random(seed);
            wd[11:8] = i[3:0];
            bus(1'b1, TSB_OFS_CONFIG, wd, rv);
            if (i < 12 || i == 15) m_tmode = i[3:0];
            bus(1'b0, TSB_OFS_CONFIG, 32'h0, rv);
            chk("config", {20'h0, m_tmode, 5'h0, wd[2:0]}, rv);
            chk("test mode", {28'h0, m_tmode}, {28'h0, tmode});
            chk("short test", {31'h0, m_tmode == TSB_TMODE_SHORT}, {31'h0, short_t});
        end
        // every delay code, then a set longer than its delay
        for (int k = 0; k < 9; k++) begin
            code = k < 8 ? k : 1;
            set_cyc <= k < 8 ? 8'h03 : 8'h19;
            bus(1'b1, TSB_OFS_CONFIG, 32'(code), rv);
            bus(1'b1, TSB_OFS_CONTROL, k[0] ? 32'h11 : 32'h01, rv);
            n0 = starts.size();
            pen <= 1'b1;
            wait_for(n0 + 3);
            chk_gaps(n0, code);
            pen <= 1'b0;
            wait_for(0);
            bus(1'b0, TSB_OFS_STATUS, 32'h0, rv);
            chk("rearmed", 32'h1, {30'h0, rv[5:4]});
        end
        bus(1'b0, TSB_OFS_SETCOUNT, 32'h0, rv);
        chk("set count", {16'h0, 16'(starts.size())}, rv);
        bus(1'b1, TSB_OFS_CONTROL, 32'h100, rv);
        bus(1'b1, TSB_OFS_CONFIG, 32'h3, rv);
        n0 = starts.size();
        bus(1'b1, TSB_OFS_CONTROL, 32'h10, rv);
        repeat (20) @(posedge clock_in);
        chk("host launch without pen", 32'(n0), 32'(starts.size()));
        pen <= 1'b1;
        repeat (6) @(posedge clock_in);
        bus(1'b1, TSB_OFS_CONTROL, 32'h10, rv);
        wait_for(n0 + 3);
        chk_gaps(n0, 3);
        pen <= 1'b0;
        wait_for(0);
        bus(1'b0, TSB_OFS_STATUS, 32'h0, rv);
        chk("host idle", 32'h0, {30'h0, rv[5:4]});
        bus(1'b1, TSB_OFS_CONFIG, 32'h7, rv);
        bus(1'b1, TSB_OFS_CONTROL, 32'h1, rv);
        n0 = starts.size();
        pen <= 1'b1;
        wait_for(n0 + 1);
        repeat (40) @(posedge clock_in);
        n0 = starts.size();
        n1 = n_abort;
        bus(1'b1, TSB_OFS_CONTROL, 32'h101, rv);
        repeat (60) @(posedge clock_in);
        chk("abort pulses", 32'h1, 32'(n_abort - n1));
        chk("starts after stop", 32'(n0), 32'(starts.size()));
        bus(1'b0, TSB_OFS_CONTROL, 32'h0, rv);
        chk("stop self clears", 32'h1, rv);
        bus(1'b1, TSB_OFS_CONTROL, 32'h1, rv);
        wait_for(n0 + 1);
        rst_b_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        chk("busy in reset", 32'h0, {31'h0, busy});
        rst_b_in <= 1'b1;
        n0 = starts.size();
        repeat (30) @(posedge clock_in);
        chk("starts after reset", 32'(n0), 32'(starts.size()));
        pen <= 1'b0;
        tally_and_finish();
    end
endmodule
